// file: core/oscg_pkg.sv
package oscg_pkg;

  // Register indexes; byte address on the bus is four times the index
  localparam logic [19:0] IDX_PERIPH_GATE   = 20'hF00F0;
  localparam logic [19:0] IDX_RUN_CONTROL   = 20'hFFFA1;
  localparam logic [19:0] IDX_SETTLE_STATUS = 20'hFFFA2;
  localparam logic [19:0] IDX_SETTLE_SELECT = 20'hFFFA3;
  localparam int          ADR_W             = 22;

  // Values after reset
  localparam logic [7:0] RST_PERIPH_GATE   = 8'h00;
  localparam logic [7:0] RST_RUN_CONTROL   = 8'h80;
  localparam logic [7:0] RST_SETTLE_STATUS = 8'h00;
  localparam logic [2:0] RST_SETTLE_SELECT = 3'h7;

  // Field positions in the run control register
  localparam int BIT_EXT_OSC_HALT  = 7;
  localparam int BIT_FAST_OSC_HALT = 0;

  // Field positions in the peripheral clock gate register
  localparam int BIT_INTERVAL_TIMER_GATE = 7;
  localparam int BIT_COMPARATOR_GATE     = 6;
  localparam int BIT_ADC_GATE            = 5;
  localparam int BIT_I2C_UNIT_GATE       = 4;
  localparam int BIT_SERIAL_ARRAY_GATE   = 2;
  localparam int BIT_TIMER_ARRAY_GATE    = 0;
  localparam logic [7:0] PERIPH_GATE_MASK = 8'hF5;

  // Pin mode, {external_clock_pin_select, oscillator_pin_select}
  localparam logic [1:0] PIN_MODE_OSC = 2'h1;
  localparam logic [1:0] PIN_MODE_EXT = 2'h3;

  // Settle counter: limit is 2^n + 16 fx cycles
  localparam int          CNT_W         = 19;
  localparam logic [18:0] SETTLE_OFFSET = 19'h00010;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_COUNT = 2'b01,
    ST_DONE  = 2'b10
  } oscg_settle_state_t;

  // Exponent n for each select code
  function automatic logic [4:0] settle_exp(input logic [2:0] code);
    case (code)
      3'h0:    settle_exp = 5'h08;
      3'h1:    settle_exp = 5'h09;
      3'h2:    settle_exp = 5'h0A;
      3'h3:    settle_exp = 5'h0B;
      3'h4:    settle_exp = 5'h0D;
      3'h5:    settle_exp = 5'h0F;
      3'h6:    settle_exp = 5'h11;
      default: settle_exp = 5'h12;
    endcase
  endfunction

  function automatic logic [18:0] settle_limit(input logic [2:0] code);
    settle_limit = (19'h00001 << settle_exp(code)) + SETTLE_OFFSET;
  endfunction

endpackage

// file: core/oscg_settle_counter.sv
`timescale 1ns/100ps
module oscg_settle_counter
  import oscg_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       fx_in,
  input  wire logic       clear_in,
  input  wire logic       start_in,
  input  wire logic [2:0] select_in,
  output logic [7:0]      status_out,
  output logic            done_out
);

  logic                      fx_s1_reg;
  logic                      fx_s2_reg;
  logic                      fx_s3_reg;
  logic                      fx_edge;
  logic [CNT_W-1:0]          count_reg;
  oscg_settle_state_t        state_reg;
  logic [7:0]                status_reg;

  // fx is foreign to CLK_IN; stage one feeds only stage two
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fx_s1_reg <= 1'b0;
      fx_s2_reg <= 1'b0;
      fx_s3_reg <= 1'b0;
    end else begin
      fx_s1_reg <= fx_in;
      fx_s2_reg <= fx_s1_reg;
      fx_s3_reg <= fx_s2_reg;
    end
  end

  // Only real fx edges advance, so start-up time before oscillation is not counted
  assign fx_edge = fx_s2_reg & ~fx_s3_reg;

  // Count fx edges up to the selected limit, then hold
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= ST_IDLE;
      count_reg <= '0;
    end else if (clear_in) begin
      state_reg <= ST_IDLE;
      count_reg <= '0;
    end else if (start_in) begin
      state_reg <= ST_COUNT;
      count_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_IDLE;
        end
        ST_COUNT: begin
          if (count_reg >= settle_limit(select_in)) begin
            state_reg <= ST_DONE;
          end else if (fx_edge) begin
            count_reg <= count_reg + 19'h00001;
          end
        end
        ST_DONE: begin
          state_reg <= ST_DONE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Thermometer status: bit 7 first, each sticky until cleared
  for (genvar k = 0; k < 8; k++) begin : g_status
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        status_reg[7-k] <= 1'b0;
      end else if (clear_in || start_in) begin
        status_reg[7-k] <= 1'b0;
      end else if (count_reg >= settle_limit(3'(k))) begin
        status_reg[7-k] <= 1'b1;
      end
    end
  end

  assign status_out = status_reg;
  assign done_out   = (state_reg == ST_DONE);

endmodule

// file: core/oscg_top.sv
`timescale 1ns/100ps
module oscg_top
  import oscg_pkg::*;
(
  input  wire logic              CLK_IN,
  input  wire logic              RSTN_IN,
  // Wishbone classic slave
  input  wire logic              CYC_I,
  input  wire logic              STB_I,
  input  wire logic              WE_I,
  input  wire logic [ADR_W-1:0]  ADR_I,
  input  wire logic [3:0]        SEL_I,
  input  wire logic [31:0]       DAT_I,
  output logic [31:0]            DAT_O,
  output logic                   ACK_O,
  // Surrounding clock generator
  input  wire logic              EXT_CLK_PIN_SEL_IN,
  input  wire logic              OSC_PIN_SEL_IN,
  input  wire logic              MAIN_CLK_SRC_IN,
  input  wire logic              STOP_ENTER_IN,
  input  wire logic              STOP_RELEASE_IN,
  input  wire logic              FX_CLK_IN,
  // Oscillator controls
  output logic                   EXT_OSC_RUN_OUT,
  output logic                   EXT_CLK_EN_OUT,
  output logic                   FAST_OSC_RUN_OUT,
  output logic                   CPU_HOLD_OUT,
  // Peripheral gating
  output logic [7:0]             PERIPH_CLK_EN_OUT,
  output logic [7:0]             PERIPH_WR_EN_OUT,
  output logic [7:0]             PERIPH_RSTN_OUT
);

  import oscg_pkg::*;

  logic              req;
  logic              ack_reg;
  logic [31:0]       rdata_reg;
  logic [31:0]       rdata_next;
  logic              addr_ok;
  logic [19:0]       idx;
  logic              wr_fire;
  logic [7:0]        wbyte;
  logic [7:0]        gate_reg;
  logic              ext_halt_reg;
  logic              fast_halt_reg;
  logic [2:0]        select_reg;
  logic [1:0]        pin_mode;
  logic              fx_mode;
  logic              ext_halt_eff;
  logic              start_reg;
  logic              settle_clear;
  logic [7:0]        settle_status;
  logic              settle_done;
  logic              hold_reg;
  logic              ext_run_reg;
  logic              ext_clk_reg;
  logic              fast_run_reg;
  logic [7:0]        clk_en_reg;
  logic [7:0]        wr_en_reg;
  logic [7:0]        rstn_reg;

  // Bus decode; only word-aligned addresses are mapped
  assign req     = CYC_I & STB_I;
  assign idx     = ADR_I[ADR_W-1:2];
  assign addr_ok = (ADR_I[1:0] == 2'h0);
  assign wbyte   = DAT_I[7:0];

  // Write lands on the edge where the master sees ack
  assign wr_fire = req & WE_I & ack_reg & SEL_I[0] & addr_ok;

  // Pin mode decides what the external halt bit may do
  assign pin_mode = {EXT_CLK_PIN_SEL_IN, OSC_PIN_SEL_IN};
  assign fx_mode  = OSC_PIN_SEL_IN;

  // A running CPU source must not be cut, so the stored halt is held off
  assign ext_halt_eff = ext_halt_reg & ~MAIN_CLK_SRC_IN;

  // Status clears while the stored halt bit is set or on entering STOP
  assign settle_clear = ext_halt_reg | STOP_ENTER_IN;

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Read mux; unmapped reads return zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (addr_ok) begin
      case (idx)
        IDX_PERIPH_GATE: begin
          rdata_next[7:0] = gate_reg;
        end
        IDX_RUN_CONTROL: begin
          rdata_next[BIT_EXT_OSC_HALT]  = ext_halt_reg;
          rdata_next[BIT_FAST_OSC_HALT] = fast_halt_reg;
        end
        IDX_SETTLE_STATUS: begin
          rdata_next[7:0] = settle_status;
        end
        IDX_SETTLE_SELECT: begin
          rdata_next[2:0] = select_reg;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // Read data captured at request, stable while ack is high
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req & ~ack_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  // Peripheral gate register, reserved bits forced low
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      gate_reg <= RST_PERIPH_GATE;
    end else if (wr_fire && idx == IDX_PERIPH_GATE) begin
      gate_reg <= wbyte & PERIPH_GATE_MASK;
    end
  end

  // External halt: a set is refused while the pins are an input port
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ext_halt_reg <= RST_RUN_CONTROL[BIT_EXT_OSC_HALT];
    end else if (wr_fire && idx == IDX_RUN_CONTROL) begin
      if (wbyte[BIT_EXT_OSC_HALT] == 1'b0 || fx_mode) begin
        ext_halt_reg <= wbyte[BIT_EXT_OSC_HALT];
      end
    end
  end

  // Fast internal oscillator halt, plain store
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      fast_halt_reg <= RST_RUN_CONTROL[BIT_FAST_OSC_HALT];
    end else if (wr_fire && idx == IDX_RUN_CONTROL) begin
      fast_halt_reg <= wbyte[BIT_FAST_OSC_HALT];
    end
  end

  // Wait-time select; changing it mid-wait moves the stop point
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      select_reg <= RST_SETTLE_SELECT;
    end else if (wr_fire && idx == IDX_SETTLE_SELECT) begin
      select_reg <= wbyte[2:0];
    end
  end

  // Start pulse on halt release in crystal mode, or on STOP release
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= STOP_RELEASE_IN
                 | (wr_fire && idx == IDX_RUN_CONTROL && ext_halt_reg
                    && !wbyte[BIT_EXT_OSC_HALT] && pin_mode == PIN_MODE_OSC);
    end
  end

  // Settle counter, advanced by sampled fx edges
  oscg_settle_counter u_settle (
    .clk_in     (CLK_IN),
    .rstn_in    (RSTN_IN),
    .fx_in      (FX_CLK_IN),
    .clear_in   (settle_clear),
    .start_in   (start_reg),
    .select_in  (select_reg),
    .status_out (settle_status),
    .done_out   (settle_done)
  );

  // CPU hold after STOP release when crystal-mode fx drives the CPU
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      hold_reg <= 1'b0;
    end else if (STOP_RELEASE_IN && MAIN_CLK_SRC_IN && pin_mode == PIN_MODE_OSC) begin
      hold_reg <= 1'b1;
    end else if (hold_reg && settle_done && !start_reg) begin
      hold_reg <= 1'b0;
    end
  end

  // External oscillator enables follow the pin mode and effective halt; the fast one follows its own halt bit
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ext_run_reg  <= 1'b0;
      ext_clk_reg  <= 1'b0;
      fast_run_reg <= 1'b1;
    end else begin
      ext_run_reg  <= (pin_mode == PIN_MODE_OSC) & ~ext_halt_eff;
      ext_clk_reg  <= (pin_mode == PIN_MODE_EXT) & ~ext_halt_eff;
      fast_run_reg <= ~fast_halt_reg;
    end
  end

  // Gate outputs: clock, write permission and reset release per bit
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      clk_en_reg <= 8'h00;
      wr_en_reg  <= 8'h00;
      rstn_reg   <= 8'h00;
    end else begin
      clk_en_reg <= gate_reg;
      wr_en_reg  <= gate_reg;
      rstn_reg   <= gate_reg;
    end
  end

  // Outputs straight from flops
  assign DAT_O             = rdata_reg;
  assign ACK_O             = ack_reg;
  assign EXT_OSC_RUN_OUT   = ext_run_reg;
  assign EXT_CLK_EN_OUT    = ext_clk_reg;
  assign FAST_OSC_RUN_OUT  = fast_run_reg;
  assign CPU_HOLD_OUT      = hold_reg;
  assign PERIPH_CLK_EN_OUT = clk_en_reg;
  assign PERIPH_WR_EN_OUT  = wr_en_reg;
  assign PERIPH_RSTN_OUT   = rstn_reg;

endmodule

// file: bench/oscg_properties.sv
`timescale 1ns/100ps
module oscg_properties
  import oscg_pkg::*;
(
  input wire logic             CLK_IN,
  input wire logic             RSTN_IN,
  input wire logic             CYC_I,
  input wire logic             STB_I,
  input wire logic             WE_I,
  input wire logic [ADR_W-1:0] ADR_I,
  input wire logic [3:0]       SEL_I,
  input wire logic [31:0]      DAT_I,
  input wire logic             ACK_O,
  input wire logic             EXT_CLK_PIN_SEL_IN,
  input wire logic             OSC_PIN_SEL_IN,
  input wire logic             MAIN_CLK_SRC_IN,
  input wire logic             STOP_RELEASE_IN,
  input wire logic             EXT_OSC_RUN_OUT,
  input wire logic             EXT_CLK_EN_OUT,
  input wire logic             FAST_OSC_RUN_OUT,
  input wire logic             CPU_HOLD_OUT,
  input wire logic [7:0]       PERIPH_CLK_EN_OUT,
  input wire logic [7:0]       PERIPH_WR_EN_OUT,
  input wire logic [7:0]       PERIPH_RSTN_OUT
);
  logic        wr_any;
  logic        wr_run;
  logic        wr_gate;
  logic [19:0] hold_cnt_reg;

  // Writes that complete at this edge
  assign wr_any  = CYC_I && STB_I && WE_I && ACK_O && SEL_I[0];
  assign wr_run  = wr_any && (ADR_I == {IDX_RUN_CONTROL, 2'h0});
  assign wr_gate = wr_any && (ADR_I == {IDX_PERIPH_GATE, 2'h0});

  // Length of the current hold, checked when it ends
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      hold_cnt_reg <= 20'h00000;
    end else if (CPU_HOLD_OUT) begin
      hold_cnt_reg <= hold_cnt_reg + 20'h00001;
    end else begin
      hold_cnt_reg <= 20'h00000;
    end
  end

  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  AST_ACK_TAKEN:
    assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("ack missing");
  AST_ACK_SPUR:
    assert property (!(CYC_I && STB_I) |=> !ACK_O) else $error("ack without request");
  AST_GATE_COPY:
    assert property ((PERIPH_WR_EN_OUT == PERIPH_CLK_EN_OUT)
      && (PERIPH_RSTN_OUT == PERIPH_CLK_EN_OUT)) else $error("gate outputs disagree");
  AST_GATE_RSVD:
    assert property ((PERIPH_CLK_EN_OUT & 8'h0A) == 8'h00) else $error("reserved gate set");
  AST_GATE_WR:
    assert property (wr_gate |-> ##2 PERIPH_CLK_EN_OUT == ($past(DAT_I[7:0], 2) & 8'hF5))
      else $error("gate write not applied");
  AST_EXT_HALT:
    assert property (wr_run && DAT_I[7] && OSC_PIN_SEL_IN && !MAIN_CLK_SRC_IN
      |-> ##[1:3] !EXT_OSC_RUN_OUT && !EXT_CLK_EN_OUT) else $error("fx not stopped");
  AST_FX_KEEP:
    assert property (wr_run && DAT_I[7] && MAIN_CLK_SRC_IN && EXT_OSC_RUN_OUT
      |=> EXT_OSC_RUN_OUT [*3]) else $error("fx stopped while cpu clock");
  AST_FAST_HALT:
    assert property (wr_run && DAT_I[0] |-> ##[1:3] !FAST_OSC_RUN_OUT)
      else $error("fast osc not halted");
  AST_HOLD_RISE:
    assert property (STOP_RELEASE_IN && MAIN_CLK_SRC_IN && OSC_PIN_SEL_IN
      && !EXT_CLK_PIN_SEL_IN |=> CPU_HOLD_OUT) else $error("hold not raised");
  AST_HOLD_LEN:
    assert property ($fell(CPU_HOLD_OUT) |-> hold_cnt_reg >= 20'h00110)
      else $error("hold too short");
endmodule

// file: bench/oscg_top_bench.sv
`timescale 1ns/100ps
module oscg_top_bench;
  import oscg_pkg::*;
  logic        CLK_IN, RSTN_IN, CYC_I, STB_I, WE_I, ACK_O;
  logic [21:0] ADR_I;
  logic [3:0]  SEL_I;
  logic [31:0] DAT_I, DAT_O;
  logic        EXT_CLK_PIN_SEL_IN, OSC_PIN_SEL_IN, MAIN_CLK_SRC_IN;
  logic        STOP_ENTER_IN, STOP_RELEASE_IN, FX_CLK_IN;
  logic        EXT_OSC_RUN_OUT, EXT_CLK_EN_OUT, FAST_OSC_RUN_OUT, CPU_HOLD_OUT;
  logic [7:0]  PERIPH_CLK_EN_OUT, PERIPH_WR_EN_OUT, PERIPH_RSTN_OUT;
  logic [1:0]  fx_cnt;
  int          num_errors, num_checks;

  oscg_top u_dut (.*);

  initial begin
    CLK_IN = 1'b0;
    forever #50 CLK_IN = ~CLK_IN;
  end

  // fx only toggles while an oscillator source is enabled, as real silicon
  always @(posedge CLK_IN) begin
    if (EXT_OSC_RUN_OUT || EXT_CLK_EN_OUT) begin
      fx_cnt <= fx_cnt + 2'h1;
    end
  end
  assign FX_CLK_IN = fx_cnt[1];

  task give_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Classic single cycle; bounded wait for the answer
  task wb(input logic w, input logic [19:0] idx, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge CLK_IN);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I  <= w;
    ADR_I <= {idx, 2'h0};
    DAT_I <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge CLK_IN);
      n++;
    end while (ACK_O !== 1'b1 && n < 20);
    chk(ACK_O, 8'h01);
    q = DAT_O[7:0];
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
  endtask

  task wr(input logic [19:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, q);
  endtask

  task rd(input logic [19:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, idx, 8'h00, q);
    chk(q, exp);
  endtask

  task t_reset;
    chk(FAST_OSC_RUN_OUT, 8'h01);
    chk(PERIPH_RSTN_OUT, 8'h00);
    rd(IDX_PERIPH_GATE, 8'h00);
    rd(IDX_SETTLE_STATUS, 8'h00);
    rd(IDX_SETTLE_SELECT, 8'h07);
    rd(20'h00123, 8'h00);
  endtask

  task t_gate;
    wr(IDX_PERIPH_GATE, 8'hFF);
    rd(IDX_PERIPH_GATE, 8'hF5);
    chk(PERIPH_CLK_EN_OUT & PERIPH_WR_EN_OUT, 8'hF5);
    wr(IDX_PERIPH_GATE, 8'h21);
    rd(IDX_PERIPH_GATE, 8'h21);
    chk(PERIPH_RSTN_OUT, 8'h21);
  endtask

  task t_settle;
    int n;
    logic [7:0] q;
    wr(IDX_SETTLE_SELECT, 8'h00);
    wr(IDX_RUN_CONTROL, 8'h00);
    repeat (3) @(posedge CLK_IN);
    chk(EXT_OSC_RUN_OUT, 8'h01);
    n = 0;
    q = 8'h00;
    while (q === 8'h00 && n < 2000) begin
      wb(1'b0, IDX_SETTLE_STATUS, 8'h00, q);
      n++;
    end
    chk(q, 8'h80);
    repeat (2500) @(posedge CLK_IN);
    rd(IDX_SETTLE_STATUS, 8'h80);
    wr(IDX_SETTLE_SELECT, 8'h01);
    @(posedge CLK_IN);
    STOP_ENTER_IN <= 1'b1;
    @(posedge CLK_IN);
    STOP_ENTER_IN <= 1'b0;
    rd(IDX_SETTLE_STATUS, 8'h00);
    MAIN_CLK_SRC_IN <= 1'b1;
    @(posedge CLK_IN);
    STOP_RELEASE_IN <= 1'b1;
    @(posedge CLK_IN);
    STOP_RELEASE_IN <= 1'b0;
    repeat (2) @(posedge CLK_IN);
    chk(CPU_HOLD_OUT, 8'h01);
    n = 0;
    while (CPU_HOLD_OUT === 1'b1 && n < 8000) begin
      @(posedge CLK_IN);
      n++;
    end
    chk(CPU_HOLD_OUT, 8'h00);
    rd(IDX_SETTLE_STATUS, 8'hC0);
    repeat (3000) @(posedge CLK_IN);
    rd(IDX_SETTLE_STATUS, 8'hC0);
  endtask

  // Halt writes in fx, crystal, external clock and input port modes
  task t_halt;
    wr(IDX_RUN_CONTROL, 8'h80);
    repeat (3) @(posedge CLK_IN);
    chk(EXT_OSC_RUN_OUT, 8'h01);
    rd(IDX_RUN_CONTROL, 8'h80);
    MAIN_CLK_SRC_IN <= 1'b0;
    wr(IDX_RUN_CONTROL, 8'h80);
    repeat (3) @(posedge CLK_IN);
    chk(EXT_OSC_RUN_OUT, 8'h00);
    rd(IDX_SETTLE_STATUS, 8'h00);
    EXT_CLK_PIN_SEL_IN <= 1'b1;
    wr(IDX_RUN_CONTROL, 8'h00);
    repeat (3) @(posedge CLK_IN);
    chk({EXT_CLK_EN_OUT, EXT_OSC_RUN_OUT}, 8'h02);
    wr(IDX_RUN_CONTROL, 8'h80);
    repeat (3) @(posedge CLK_IN);
    chk({EXT_CLK_EN_OUT, EXT_OSC_RUN_OUT}, 8'h00);
    EXT_CLK_PIN_SEL_IN <= 1'b0;
    OSC_PIN_SEL_IN <= 1'b0;
    wr(IDX_RUN_CONTROL, 8'h00);
    wr(IDX_RUN_CONTROL, 8'h80);
    rd(IDX_RUN_CONTROL, 8'h00);
    MAIN_CLK_SRC_IN <= 1'b1;
    wr(IDX_RUN_CONTROL, 8'h01);
    repeat (3) @(posedge CLK_IN);
    chk(FAST_OSC_RUN_OUT, 8'h00);
    wr(IDX_RUN_CONTROL, 8'h00);
    repeat (3) @(posedge CLK_IN);
    chk(FAST_OSC_RUN_OUT, 8'h01);
  endtask

  // Bounded by the longest expected run
  initial begin
    repeat (40000) @(posedge CLK_IN);
    num_errors++;
    give_verdict;
  end

  initial begin
    num_errors = 0;
    num_checks = 0;
    fx_cnt = 2'h0;
    RSTN_IN = 1'b0;
    {CYC_I, STB_I, WE_I, STOP_ENTER_IN, STOP_RELEASE_IN} = 5'h00;
    ADR_I = 22'h000000;
    SEL_I = 4'hF;
    DAT_I = 32'h00000000;
    EXT_CLK_PIN_SEL_IN = 1'b0;
    OSC_PIN_SEL_IN = 1'b1;
    MAIN_CLK_SRC_IN = 1'b0;
    repeat (2) @(posedge CLK_IN);
    RSTN_IN <= 1'b1;
    @(posedge CLK_IN);
    t_reset;
    t_gate;
    t_settle;
    t_halt;
    give_verdict;
  end
endmodule

bind oscg_top oscg_properties u_props (.*);
